// *** design/spi_eeprom_command_protect.sv ***
`timescale 1ns/1ps
`include "eeprom_defines.svh"
// Overview of operation
// - sample si on each unpaused rising sck edge
// - change so on falling sck edges
// - select high: so off, writes continue
// - pause input holds transfer, no restart
// - first byte is opcode; decode enable/disable/status-read
// - only six opcodes accepted, others ignored
// - decode array read opcode
// - decode array write opcode
// - status byte layout with fixed zeros
// - busy flag follows internal write cycle
// - latch set and cleared by commands
// - guard bits loaded only by status write
// - guard bits select protected address range
// - guard pin plus enable locks status
// - latch and guard gate every write
// - latch set only when select ends opcode
// - sixteen address bits, low twelve used
// - programming starts at closing select edge
// - during write only status read accepted
// - page load of 32 bytes wraps
// - latch cleared after write and power-up
// - status write changes bits 7,3,2 only
// - array read increments and wraps address
// - status read during write returns ones
// - pause tri-states so and ignores si
module spi_eeprom_command_protect
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES, // internal write length
  parameter int unsigned ARRAY_AW     = `ARRAY_AW,     // array address width
  parameter int unsigned PAGE_AW      = `PAGE_AW       // in-page address width
) (
  input  wire logic clock,       // system clock
  input  wire logic rst,         // async reset, active high
  input  wire logic cs_n,        // chip select, active low
  input  wire logic sck,         // serial clock from host
  input  wire logic si,          // serial data in
  input  wire logic hold_n,      // pause input, active low
  input  wire logic guard_pin_n, // guard pin, active low
  output logic      so,          // serial data out
  output logic      so_oe        // so drive enable
);

  localparam int unsigned PAGE_BYTES = 1 << PAGE_AW;
  localparam int unsigned DEPTH      = 1 << ARRAY_AW;
  localparam int unsigned CW         = $clog2(WRITE_CYCLES + 1);
  localparam logic [CW-1:0] WC_LAST  = CW'(WRITE_CYCLES - 1);

  // ------------------------------------------------------------
  // storage array
  // ------------------------------------------------------------
  // written on clock, read on sck; reads are refused while busy
  logic [7:0] mem [DEPTH];

  // ------------------------------------------------------------
  // link domain declarations
  // ------------------------------------------------------------
  logic                link_rst;
  link_state_e         state_q;
  logic [7:0]          shift_q;
  logic [2:0]          bit_q;
  logic                addr_byte_q;
  logic [15:0]         addr_q;
  logic [7:0]          op_q;
  logic [7:0]          tx_q;
  logic [ARRAY_AW-1:0] rd_ptr_q;
  logic [PAGE_AW-1:0]  wr_idx_q;
  logic                any_q;
  logic [7:0]          sr_data_q;
  logic [7:0]          sr_s1_q;
  logic [7:0]          sr_s2_q;
  logic [7:0]          sr_q;
  logic                so_q;
  logic [PAGE_BYTES-1:0] mask_q;
  logic [7:0]          page_buf [PAGE_BYTES];
  logic [7:0]          byte_in;
  logic                byte_end;
  logic                busy_s;
  logic [7:0]          status_out;
  logic [ARRAY_AW-1:0] addr_full;
  end_cmd_e            end_cmd_d;

  // closing-edge capture
  end_cmd_e            end_cmd_q;
  logic                end_tgl_q;
  logic [ARRAY_AW-1:0] end_addr_q;
  logic [7:0]          end_sr_q;

  // ------------------------------------------------------------
  // system domain declarations
  // ------------------------------------------------------------
  logic                ts1_q;
  logic                ts2_q;
  logic                ts3_q;
  logic                gp1_q;
  logic                gp2_q;
  logic                guard_en_q;
  logic [1:0]          guard_q;
  logic                wel_q;
  logic                busy_q;
  logic [CW-1:0]       cnt_q;
  logic                prog_q;
  logic [PAGE_AW-1:0]  prog_idx_q;
  logic [ARRAY_AW-PAGE_AW-1:0] prog_page_q;
  logic                end_ev;
  logic                hw_lock;
  logic                page_guarded;
  logic                accept_write;
  logic                accept_status_write_cmd;
  logic [7:0]          status_word;

  // select high clears the whole link sequence
  assign link_rst = rst | cs_n;

  assign byte_in  = {shift_q[6:0], si};
  // a paused edge is not a data edge
  assign byte_end = hold_n && (bit_q == 3'h7);
  assign busy_s   = sr_q[`SR_BUSY_BIT];
  assign addr_full = {addr_q[ARRAY_AW-9:0], byte_in};

  assign status_out = busy_s ? `SR_BUSY_VALUE : sr_q;

  // opcode to next state; busy blocks all but status read
  function automatic link_state_e decode(input logic [7:0] op, input logic busy);
    link_state_e nxt;
    nxt = LS_IGN;
    case (op)
      `OPC_WRITE_LATCH_SET_CMD_CODE:  nxt = LS_DONE;
      `OPC_WRITE_LATCH_CLEAR_CMD_CODE:  nxt = LS_DONE;
      `OPC_STATUS_READ_CMD_CODE:  nxt = LS_STATUS_READ_CMD;
      `OPC_STATUS_WRITE_CMD_CODE:  nxt = LS_SRDATA;
      `OPC_READ_CODE:  nxt = LS_ADDR;
      `OPC_WRITE_CODE: nxt = LS_ADDR;
      default:         nxt = LS_IGN;
    endcase
    if (busy && op != `OPC_STATUS_READ_CMD_CODE) begin
      nxt = LS_IGN;
    end
    return nxt;
  endfunction

  // ------------------------------------------------------------
  // status crossing into the link domain
  // ------------------------------------------------------------
  // word taken only when two samples agree: busy and latch move together
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      sr_s1_q <= `SR_RESET_VALUE;
      sr_s2_q <= `SR_RESET_VALUE;
      sr_q    <= `SR_RESET_VALUE;
    end else begin
      sr_s1_q <= status_word;
      sr_s2_q <= sr_s1_q;
      if (sr_s1_q == sr_s2_q) begin
        sr_q <= sr_s2_q;
      end
    end
  end

  // ------------------------------------------------------------
  // link sequencer (rising sck)
  // ------------------------------------------------------------
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      state_q     <= LS_OPC;
      shift_q     <= 8'h00;
      bit_q       <= 3'h0;
      addr_byte_q <= 1'b0;
      addr_q      <= 16'h0000;
      op_q        <= 8'h00;
      tx_q        <= 8'h00;
      rd_ptr_q    <= '0;
      wr_idx_q    <= '0;
      any_q       <= 1'b0;
      sr_data_q   <= 8'h00;
    end else if (hold_n) begin
      shift_q <= byte_in;
      bit_q   <= bit_q + 3'h1;
      case (state_q)
        LS_OPC: begin
          if (byte_end) begin
            op_q    <= byte_in;
            state_q <= decode(byte_in, busy_s);
            tx_q    <= status_out;
          end
        end
        LS_ADDR: begin
          if (byte_end) begin
            addr_q      <= {addr_q[7:0], byte_in};
            addr_byte_q <= 1'b1;
            if (addr_byte_q) begin
              if (op_q == `OPC_READ_CODE) begin
                state_q  <= LS_RDARR;
                tx_q     <= mem[addr_full];
                rd_ptr_q <= addr_full + ARRAY_AW'(1);
              end else begin
                state_q  <= LS_WDATA;
                wr_idx_q <= addr_full[PAGE_AW-1:0];
              end
            end
          end
        end
        LS_WDATA: begin
          if (byte_end) begin
            wr_idx_q <= wr_idx_q + PAGE_AW'(1);
            any_q    <= 1'b1;
          end
        end
        LS_RDARR: begin
          // pointer wraps from top to zero
          if (byte_end) begin
            tx_q     <= mem[rd_ptr_q];
            rd_ptr_q <= rd_ptr_q + ARRAY_AW'(1);
          end
        end
        LS_STATUS_READ_CMD: begin
          // status repeats until select rises
          if (byte_end) begin
            tx_q <= status_out;
          end
        end
        LS_SRDATA: begin
          // first whole byte is the new status
          if (byte_end) begin
            if (!any_q) begin
              sr_data_q <= byte_in;
            end
            any_q <= 1'b1;
          end
        end
        LS_DONE: begin
          // extra clocks void the latch command
          state_q <= LS_IGN;
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // page load buffer
  // ------------------------------------------------------------
  // not cleared by select: the system side reads it after the frame
  for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
    logic [7:0] ent_q;
    always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
        ent_q <= 8'h00;
      // byte lands at its in-page index
      end else if (!cs_n && state_q == LS_WDATA && byte_end
                   && wr_idx_q == PAGE_AW'(i)) begin
        ent_q <= byte_in;
      end
    end
    assign page_buf[i] = ent_q;
  end

  // valid mask, restarted by each accepted write opcode
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (!cs_n && state_q == LS_OPC && byte_end
                 && byte_in == `OPC_WRITE_CODE && !busy_s) begin
      mask_q <= '0;
    end else if (!cs_n && state_q == LS_WDATA && byte_end) begin
      mask_q[wr_idx_q] <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // output shifter (falling sck)
  // ------------------------------------------------------------
  // new bit on each unpaused falling edge, msb first
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      so_q <= 1'b0;
    end else if (hold_n) begin
      so_q <= tx_q[~bit_q];
    end
  end

  assign so = so_q;
  // select high or pause releases so
  assign so_oe = !cs_n && hold_n && (state_q == LS_RDARR || state_q == LS_STATUS_READ_CMD);

  // ------------------------------------------------------------
  // end of frame
  // ------------------------------------------------------------
  // what the frame amounts to if select rose now
  always_comb begin
    end_cmd_d = EC_NONE;
    case (state_q)
      LS_DONE: begin
        // select must rise right at the opcode boundary
        if (op_q == `OPC_WRITE_LATCH_SET_CMD_CODE) begin
          end_cmd_d = EC_WRITE_LATCH_SET_CMD;
        end else begin
          end_cmd_d = EC_WRITE_LATCH_CLEAR_CMD;
        end
      end
      LS_WDATA: begin
        // only whole bytes make a write
        if (any_q && bit_q == 3'h0) begin
          end_cmd_d = EC_WRITE;
        end
      end
      LS_SRDATA: begin
        if (any_q && bit_q == 3'h0) begin
          end_cmd_d = EC_STATUS_WRITE_CMD;
        end
      end
      default: begin
        end_cmd_d = EC_NONE;
      end
    endcase
  end

  // closing select edge hands the command over
  // sck is stopped here, so the select edge itself clocks the capture
  always_ff @(posedge cs_n or posedge rst) begin
    if (rst) begin
      end_cmd_q  <= EC_NONE;
      end_tgl_q  <= 1'b0;
      end_addr_q <= '0;
      end_sr_q   <= 8'h00;
    end else begin
      end_cmd_q  <= end_cmd_d;
      end_addr_q <= addr_q[ARRAY_AW-1:0];
      end_sr_q   <= sr_data_q;
      if (end_cmd_d != EC_NONE) begin
        end_tgl_q <= ~end_tgl_q;
      end
    end
  end

  // ------------------------------------------------------------
  // crossings into the system domain
  // ------------------------------------------------------------
  // toggle for the event, two stages for the guard pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ts1_q <= 1'b0;
      ts2_q <= 1'b0;
      ts3_q <= 1'b0;
      gp1_q <= 1'b1;
      gp2_q <= 1'b1;
    end else begin
      ts1_q <= end_tgl_q;
      ts2_q <= ts1_q;
      ts3_q <= ts2_q;
      gp1_q <= guard_pin_n;
      gp2_q <= gp1_q;
    end
  end

  assign end_ev = ts2_q ^ ts3_q;

  // pin low with enable set locks status
  assign hw_lock = !gp2_q && guard_en_q;

  // guarded range by guard bits; pages never straddle it
  always_comb begin
    case (guard_q)
      2'b01:   page_guarded = (end_addr_q >= `GUARD_QUARTER);
      2'b10:   page_guarded = (end_addr_q >= `GUARD_HALF);
      2'b11:   page_guarded = 1'b1;
      default: page_guarded = 1'b0;
    endcase
  end

  // latch and guard gate array writes
  assign accept_write = end_ev && !busy_q && end_cmd_q == EC_WRITE
                        && wel_q && !page_guarded;
  // status write needs latch and no lock
  assign accept_status_write_cmd  = end_ev && !busy_q && end_cmd_q == EC_STATUS_WRITE_CMD
                        && wel_q && !hw_lock;

  // status layout, bits 6..4 fixed zero
  always_comb begin
    status_word = `SR_RESET_VALUE;
    status_word[`SR_GUARD_EN_BIT] = guard_en_q;
    status_word[`SR_GUARD_HI_BIT] = guard_q[1];
    status_word[`SR_GUARD_LO_BIT] = guard_q[0];
    status_word[`SR_WEL_BIT]      = wel_q;
    status_word[`SR_BUSY_BIT]     = busy_q;
  end

  // ------------------------------------------------------------
  // write cycle timer
  // ------------------------------------------------------------
  // busy held for the parameter count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (accept_write || accept_status_write_cmd) begin
      busy_q <= 1'b1;
      cnt_q  <= WC_LAST;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // write enable latch
  // ------------------------------------------------------------
  // commands are refused while busy, so set and clear never meet
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
    // cleared as the write cycle ends
    end else if (busy_q && cnt_q == '0) begin
      wel_q <= 1'b0;
    end else if (end_ev && !busy_q) begin
      if (end_cmd_q == EC_WRITE_LATCH_SET_CMD) begin
        wel_q <= 1'b1;
      end else if (end_cmd_q == EC_WRITE_LATCH_CLEAR_CMD) begin
        wel_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // guard bits
  // ------------------------------------------------------------
  // reset stands in for the retained cell contents of a real part
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      guard_en_q <= 1'b0;
      guard_q    <= 2'b00;
    end else if (accept_status_write_cmd) begin
      guard_en_q <= end_sr_q[`SR_GUARD_EN_BIT];
      guard_q    <= {end_sr_q[`SR_GUARD_HI_BIT], end_sr_q[`SR_GUARD_LO_BIT]};
    end
  end

  // ------------------------------------------------------------
  // array programming
  // ------------------------------------------------------------
  // one buffer entry per cycle at the start of the write cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prog_q      <= 1'b0;
      prog_idx_q  <= '0;
      prog_page_q <= '0;
    // programming only after a valid closing edge
    end else if (accept_write) begin
      prog_q      <= 1'b1;
      prog_idx_q  <= '0;
      prog_page_q <= end_addr_q[ARRAY_AW-1:PAGE_AW];
    end else if (prog_q) begin
      prog_idx_q <= prog_idx_q + PAGE_AW'(1);
      if (prog_idx_q == '1) begin
        prog_q <= 1'b0;
      end
    end
  end

  // only loaded entries of the page are written
  always_ff @(posedge clock) begin
    if (prog_q && mask_q[prog_idx_q]) begin
      mem[{prog_page_q, prog_idx_q}] <= page_buf[prog_idx_q];
    end
  end

endmodule

// *** design/eeprom_defines.svh ***
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

// ------------------------------------------------------------
// instruction codes
// ------------------------------------------------------------
`define OPC_STATUS_WRITE_CMD_CODE   8'h01
`define OPC_WRITE_CODE  8'h02
`define OPC_READ_CODE   8'h03
`define OPC_WRITE_LATCH_CLEAR_CMD_CODE   8'h04
`define OPC_STATUS_READ_CMD_CODE   8'h05
`define OPC_WRITE_LATCH_SET_CMD_CODE   8'h06

// ------------------------------------------------------------
// status byte layout
// ------------------------------------------------------------
`define SR_GUARD_EN_BIT 7
`define SR_GUARD_HI_BIT 3
`define SR_GUARD_LO_BIT 2
`define SR_WEL_BIT      1
`define SR_BUSY_BIT     0
`define SR_BUSY_VALUE   8'hff
`define SR_RESET_VALUE  8'h00

// ------------------------------------------------------------
// array geometry and guarded regions
// ------------------------------------------------------------
`define ARRAY_AW        12
`define PAGE_AW         5
`define GUARD_QUARTER   12'hc00
`define GUARD_HALF      12'h800

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define T_WC_MS         5
`define CLOCK_KHZ       250000
`define WRITE_CYCLES    (`T_WC_MS * `CLOCK_KHZ)

`endif

// *** design/eeprom_pkg.sv ***
package eeprom_pkg;

  // link-side sequence states
  typedef enum logic [2:0] {
    LS_OPC    = 3'b000,
    LS_ADDR   = 3'b001,
    LS_WDATA  = 3'b010,
    LS_RDARR  = 3'b011,
    LS_STATUS_READ_CMD   = 3'b100,
    LS_SRDATA = 3'b101,
    LS_DONE   = 3'b110,
    LS_IGN    = 3'b111
  } link_state_e;

  // command recognised at the closing select edge
  typedef enum logic [2:0] {
    EC_NONE  = 3'b000,
    EC_WRITE_LATCH_SET_CMD  = 3'b001,
    EC_WRITE_LATCH_CLEAR_CMD  = 3'b010,
    EC_WRITE = 3'b011,
    EC_STATUS_WRITE_CMD  = 3'b100
  } end_cmd_e;

endpackage

// *** bench/spi_eeprom_command_protect_sva.sv ***
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module spi_eeprom_command_protect_sva #(
  parameter int unsigned WRITE_CYCLES = 64 // internal write length
) (
  input wire logic clock,       // system clock
  input wire logic rst,         // async reset
  input wire logic cs_n,        // chip select
  input wire logic sck,         // serial clock
  input wire logic si,          // serial data in
  input wire logic hold_n,      // pause input
  input wire logic guard_pin_n, // guard pin
  input wire logic so,          // serial data out
  input wire logic so_oe        // so drive enable
);
  logic [7:0] bits_q; // edges taken this frame, saturating
  logic [7:0] sh_q;   // recent input bits
  logic [7:0] opc_q;  // opcode of this frame

  // count taken edges; paused edges must not count
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bits_q <= 8'h00;
    end else if (hold_n && bits_q != 8'hff) begin
      bits_q <= bits_q + 8'h01;
    end
  end

  // shadow the opcode shift
  always_ff @(posedge sck) begin
    if (!cs_n && hold_n) begin
      sh_q <= {sh_q[6:0], si};
      if (bits_q == 8'h07) begin
        opc_q <= {sh_q[6:0], si};
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_status_phase;
    !cs_n && hold_n && opc_q == `OPC_STATUS_READ_CMD_CODE && bits_q >= 8'h08;
  endsequence
  sequence s_read_phase;
    !cs_n && hold_n && opc_q == `OPC_READ_CODE && bits_q >= 8'h18;
  endsequence

  chk_oe_deselect: assert property (cs_n |-> !so_oe)
    else $error("so driven while deselected");
  chk_oe_pause: assert property (!hold_n |-> !so_oe)
    else $error("so driven while paused");
  chk_so_falling: assert property ((sck && $past(sck) && so_oe && $past(so_oe)) |-> $stable(so))
    else $error("so changed while sck high");
  chk_pause_freeze: assert property ((!hold_n && !$past(hold_n)) |-> $stable(so))
    else $error("so moved during pause");
  chk_status_drive: assert property (s_status_phase |-> so_oe)
    else $error("status byte not driven");
  chk_read_drive: assert property (s_read_phase |-> so_oe)
    else $error("array data not driven");
  chk_addr_quiet: assert property ((opc_q == `OPC_READ_CODE && bits_q >= 8'h08
    && bits_q < 8'h18) |-> !so_oe)
    else $error("so driven during address");
  chk_unknown_quiet: assert property ((bits_q >= 8'h08 && opc_q != `OPC_READ_CODE
    && opc_q != `OPC_STATUS_READ_CMD_CODE) |-> !so_oe)
    else $error("so driven for non-read opcode");
endmodule

bind spi_eeprom_command_protect spi_eeprom_command_protect_sva #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_sva (
  .clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
  .guard_pin_n(guard_pin_n), .so(so), .so_oe(so_oe)
);

// *** bench/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
  output logic      cs_n,   // chip select, active low
  output logic      sck,    // serial clock, still between frames
  output logic      si,     // host data out
  output logic      hold_n, // pause, active low
  input  wire logic so,     // device data
  input  wire logic so_oe   // device drive enable
);
  logic idle_q; // sck level between frames: mode 0 or 3

  // idle levels at time zero
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    idle_q = 1'b0;
  end

  task automatic open_frame(input logic mode);
    idle_q = mode;
    sck = mode;
    #7.3 cs_n = 1'b0;
    #17;
  endtask

  // set after falling, device takes at rising
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'hxx;
    for (int i = 7; i > 7 - nbits; i--) begin
      #24 sck = 1'b0;
      si = tx[i];
      #24 sck = 1'b1;
      rx[i] = so_oe ? so : 1'bx;
    end
  endtask

  // select rises right after last bit; si released inverts
  task automatic close_frame();
    #24 sck = idle_q;
    #10 cs_n = 1'b1;
    si = ~si;
    #40;
  endtask

  // pause and resume with sck low, wiggle sck and si meanwhile
  task automatic pause(output logic seen);
    #24 sck = 1'b0;
    #6 hold_n = 1'b0;
    seen = 1'b0;
    repeat (3) begin
      si = ~si;
      #12 sck = 1'b1;
      seen = seen | so_oe;
      #12 sck = 1'b0;
    end
    #12 hold_n = 1'b1;
  endtask
endmodule

// *** bench/spi_eeprom_command_protect_tb_top.sv ***
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module spi_eeprom_command_protect_tb_top;
  localparam int unsigned WC = 2000; // shortened write cycle
  logic       clock;
  logic       rst;
  logic       guard_pin_n;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic       md;        // spi mode of next frames
  logic       seen;
  logic [7:0] rx;
  logic [7:0] mem [int]; // expected array contents
  int         mismatches;
  int         num_checks;

  spi_eeprom_command_protect #(.WRITE_CYCLES(WC)) DUT (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .guard_pin_n(guard_pin_n), .so(so), .so_oe(so_oe)
  );
  spi_host_model host (
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe)
  );

  // free running system clock
  always #2 clock = ~clock;

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic op(input logic [7:0] c);
    host.open_frame(md);
    host.shift(c, 8, rx);
    host.close_frame();
  endtask

  task automatic status(input logic [7:0] exp, input logic [7:0] mask);
    host.open_frame(md);
    host.shift(`OPC_STATUS_READ_CMD_CODE, 8, rx);
    host.shift(8'h00, 8, rx);
    host.close_frame();
    check8(rx & mask, exp);
  endtask

  // poll until not busy; bounded
  task automatic wait_ready();
    for (int n = 0; n < 40; n++) begin
      host.open_frame(md);
      host.shift(`OPC_STATUS_READ_CMD_CODE, 8, rx);
      host.shift(8'h00, 8, rx);
      host.close_frame();
      if (rx[0] === 1'b0) return;
    end
    mismatches++;
    $display("Error at %0t: ready poll timed out", $time);
    print_verdict();
  endtask

  // optional latch set, then write n bytes; ok says the bytes should land
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n, input bit en,
                    input bit ok);
    logic [11:0] p;
    if (en) op(`OPC_WRITE_LATCH_SET_CMD_CODE);
    host.open_frame(md);
    host.shift(`OPC_WRITE_CODE, 8, rx);
    host.shift(a[15:8], 8, rx);
    host.shift(a[7:0], 8, rx);
    for (int k = 0; k < n; k++) begin
      host.shift(d + 8'(k), 8, rx);
      p = {a[11:5], 5'(a[4:0] + k)};
      if (ok) mem[p] = d + 8'(k);
    end
    host.close_frame();
  endtask

  // read n bytes, upper address bits set to junk, pause before byte pz
  task automatic rd(input logic [11:0] a, input int n, input int pz);
    host.open_frame(md);
    host.shift(`OPC_READ_CODE, 8, rx);
    host.shift({4'ha, a[11:8]}, 8, rx);
    host.shift(a[7:0], 8, rx);
    for (int k = 0; k < n; k++) begin
      if (k == pz) begin
        host.pause(seen);
        check8({7'h00, seen}, 8'h00);
      end
      host.shift(8'h00, 8, rx);
      check8(rx, mem[12'(a + k)]);
    end
    host.close_frame();
  endtask

  task automatic wsr(input logic [7:0] v);
    op(`OPC_WRITE_LATCH_SET_CMD_CODE);
    host.open_frame(md);
    host.shift(`OPC_STATUS_WRITE_CMD_CODE, 8, rx);
    host.shift(v, 8, rx);
    host.close_frame();
  endtask

  task automatic guard(input logic v);
    @(posedge clock) guard_pin_n <= v;
    repeat (3) @(posedge clock);
  endtask

  task automatic t_commands();
    logic [7:0] bad [3] = '{8'ha5, 8'h07, 8'hff};
    status(8'h00, 8'hff);
    op(`OPC_WRITE_LATCH_SET_CMD_CODE);
    status(8'h02, 8'hff);
    op(`OPC_WRITE_LATCH_CLEAR_CMD_CODE);
    status(8'h00, 8'hff);
    md = 1'b1;
    op(`OPC_WRITE_LATCH_SET_CMD_CODE);
    status(8'h02, 8'hff);
    op(`OPC_WRITE_LATCH_CLEAR_CMD_CODE);
    md = 1'b0;
    host.open_frame(md);
    host.shift(`OPC_WRITE_LATCH_SET_CMD_CODE, 8, rx);
    host.shift(8'h00, 1, rx);
    host.close_frame();
    status(8'h00, 8'hff);
    foreach (bad[i]) begin
      host.open_frame(md);
      host.shift(bad[i], 8, rx);
      host.shift(8'h00, 8, rx);
      host.close_frame();
      check8(rx, 8'hxx);
    end
  endtask

  task automatic t_page();
    wr(16'hf1e3, 8'h40, 34, 1, 1);
    status(8'hff, 8'hff);
    wr(16'h01e5, 8'h00, 1, 0, 0);
    wait_ready();
    status(8'h00, 8'hff);
    rd(12'h1e0, 32, 4);
  endtask

  task automatic t_wrap();
    wr(16'h0ffe, 8'h90, 4, 1, 1);
    wait_ready();
    wr(16'h0000, 8'ha0, 2, 1, 1);
    wait_ready();
    wr(16'h0c00, 8'h11, 1, 1, 1);
    wait_ready();
    rd(12'hfff, 2, -1);
  endtask

  task automatic t_refuse();
    wr(16'h01e0, 8'h55, 1, 0, 0);
    status(8'h00, 8'hff);
    op(`OPC_WRITE_LATCH_SET_CMD_CODE);
    host.open_frame(md);
    host.shift(`OPC_WRITE_CODE, 8, rx);
    host.shift(8'h00, 8, rx);
    host.shift(8'h10, 8, rx);
    host.shift(8'h77, 4, rx);
    host.close_frame();
    status(8'h02, 8'hff);
    op(`OPC_WRITE_LATCH_CLEAR_CMD_CODE);
    rd(12'h1e0, 1, -1);
  endtask

  task automatic t_guard();
    wsr(8'h8f);
    wait_ready();
    status(8'h8c, 8'hff);
    wr(16'h0010, 8'h33, 1, 1, 0);
    status(8'h8c, 8'hfd);
    guard(1'b0);
    wsr(8'h00);
    status(8'h8c, 8'hfd);
    guard(1'b1);
    wsr(8'h84);
    wait_ready();
    status(8'h84, 8'hff);
    guard(1'b0);
    wr(16'h0c00, 8'h66, 1, 1, 0);
    status(8'h84, 8'hfd);
    wr(16'h0bff, 8'h22, 1, 1, 1);
    wait_ready();
    rd(12'hbff, 2, -1);
    guard(1'b1);
    wsr(8'h00);
    wait_ready();
    status(8'h00, 8'hff);
  endtask

  // reset, then the scenarios in turn
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    guard_pin_n = 1'b1;
    md = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_commands();
    t_page();
    t_wrap();
    t_refuse();
    t_guard();
    print_verdict();
  end
endmodule
